// [rtl/ffs_pkg.sv]
`default_nettype none
package ffs_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PARAM  = 8'h0C;
  localparam logic [7:0] OFF_VER    = 8'h10;
  localparam logic [7:0] OFF_FUSE_H = 8'h14;
  localparam logic [7:0] OFF_FUSE_L = 8'h18;

  // flash_command fields
  localparam int CMD_LSB  = 0;
  localparam int CMD_W    = 6;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_W   = 16;
  localparam int KEY_LSB  = 24;
  localparam logic [7:0] CMD_KEY = 8'hA5;

  // Command codes
  localparam logic [5:0] C_NOP   = 6'h00;
  localparam logic [5:0] C_WP    = 6'h01;
  localparam logic [5:0] C_EP    = 6'h02;
  localparam logic [5:0] C_CPB   = 6'h03;
  localparam logic [5:0] C_LP    = 6'h04;
  localparam logic [5:0] C_UP    = 6'h05;
  localparam logic [5:0] C_EA    = 6'h06;
  localparam logic [5:0] WRITE_FUSE_BIT_CMD    = 6'h07;
  localparam logic [5:0] ERASE_FUSE_BIT_CMD    = 6'h08;
  localparam logic [5:0] SET_SECURITY_CMD      = 6'h09;
  localparam logic [5:0] PROGRAM_FUSE_BYTE_CMD = 6'h0A;
  localparam logic [5:0] ERASE_ALL_FUSES_CMD   = 6'h0B;
  localparam logic [5:0] C_QPR   = 6'h0C;

  // flash_control bits
  localparam int CB_IE_RDY  = 0;
  localparam int CB_IE_LOCK = 2;
  localparam int CB_IE_PROG = 3;
  localparam int CB_WS      = 6;
  localparam int CB_SEQ     = 16;
  localparam int CB_BR      = 17;

  // flash_status bits
  localparam int SB_RDY  = 0;
  localparam int SB_LOCK = 2;
  localparam int SB_PROG = 3;
  localparam int SB_SEC  = 4;
  localparam int SB_QPR  = 5;
  localparam int SB_REG  = 16;

  // Special fuse positions
  localparam int F_EXT_PRIV_FETCH_LOCK = 16;
  localparam int F_BP_LSB = 17;
  localparam int F_BP_MSB = 19;
  localparam logic [2:0] BP_NONE = 3'h7;

  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int EXEC_TIME_NS  = 100;
  localparam int EXEC_CYC = (EXEC_TIME_NS * 1000) / CLK_PERIOD_PS;

  typedef struct packed {
    logic [5:0]  code;
    logic [15:0] page;
  } ffs_op_t;

  typedef struct packed {
    logic br_en;
    logic seq_en;
    logic ws;
    logic ie_prog;
    logic ie_lock;
    logic ie_rdy;
  } ffs_ctrl_t;
endpackage
`default_nettype wire

// [rtl/ffs_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module ffs_ctrl #(
  parameter int          PAGE_BITS = 9,
  parameter int          EXEC      = ffs_pkg::EXEC_CYC,
  parameter logic [31:0] FUSE_INIT = 32'hFFFFFFFF,
  parameter logic [31:0] PARAM_VAL = 32'h00000307,
  parameter logic [31:0] VERSION   = 32'h00000100  // Arbitrary value
) (
  input  wire logic             clk,            // System clock
  input  wire logic             rst,            // Sync reset, high
  input  wire logic             reg_wr,         // Register write strobe
  input  wire logic             reg_rd,         // Register read strobe
  input  wire logic [7:0]       reg_addr,       // Byte address
  input  wire logic [31:0]      reg_wdata,      // Write data
  output logic [31:0]           reg_rdata,      // Read data, next cycle
  input  wire logic             pbuf_wr,        // Page buffer write
  input  wire logic [15:0]      pbuf_page,      // Page of that write
  input  wire logic             qpr_erased,     // Core: page is erased
  input  wire logic             chip_erase_pin, // External chip erase
  output ffs_pkg::ffs_op_t      op,             // Operation to core
  output logic                  op_valid,       // Operation pulse
  output ffs_pkg::ffs_ctrl_t    ctrl,           // Control fields
  output logic                  ext_priv_fetch_lock, // One permits fetch
  output logic [2:0]            boot_area_size, // Boot size selector
  output logic                  irq             // Interrupt request
);
  typedef enum logic { ST_IDLE, ST_BUSY } ffs_state_t;

  localparam logic [15:0] PG_MASK = 16'((32'd1 << PAGE_BITS) - 1);
  localparam logic [15:0] EXEC_M1 = 16'(EXEC - 1);

  ffs_state_t  state_reg;
  logic [15:0] cnt_reg;
  logic [31:0] fuse_reg;
  logic        sec_reg;
  logic        prog_reg;
  logic        lock_reg;
  logic        qpr_reg;
  logic [15:0] page_reg;
  logic [5:0]  code_reg;
  logic        ce_meta;
  logic        ce_sync;

  logic        cmd_wr;
  logic        st_rd;
  logic        busy;
  logic        key_ok;
  logic        code_ok;
  logic        go;
  logic        lock_err;
  logic [5:0]  code_w;
  logic [15:0] raw_w;
  logic [15:0] page_w;
  logic [4:0]  fidx;
  logic [2:0]  fbyte;
  logic [7:0]  fval;
  logic [3:0]  region;
  logic [2:0]  bp;
  logic [15:0] boot_lim;
  logic        prog_set;
  logic        lock_set;

  assign cmd_wr = reg_wr && (reg_addr == ffs_pkg::OFF_CMD);
  assign st_rd  = reg_rd && (reg_addr == ffs_pkg::OFF_STATUS);
  assign busy   = (state_reg == ST_BUSY);
  assign code_w = reg_wdata[ffs_pkg::CMD_LSB +: ffs_pkg::CMD_W];
  assign raw_w  = reg_wdata[ffs_pkg::PAGE_LSB +: ffs_pkg::PAGE_W];
  assign page_w = raw_w & PG_MASK;
  assign key_ok = reg_wdata[ffs_pkg::KEY_LSB +: 8] == ffs_pkg::CMD_KEY;
  assign code_ok = code_w <= ffs_pkg::C_QPR;
  assign go     = cmd_wr && !busy && key_ok && code_ok;
  assign fidx   = raw_w[4:0];
  assign fbyte  = raw_w[2:0];
  assign fval   = raw_w[10:3];
  assign region = page_w[PAGE_BITS-1 -: 4];
  assign bp     = fuse_reg[ffs_pkg::F_BP_MSB:ffs_pkg::F_BP_LSB];
  // Largest selector protects nothing; each step down doubles the area
  assign boot_lim = (bp == ffs_pkg::BP_NONE) ? 16'h0000 : (16'h0001 << ~bp);

  // Refusal check, evaluated against the incoming command word
  always_comb
  begin
    lock_err = 1'b0;
    case (code_w)
      ffs_pkg::C_WP, ffs_pkg::C_EP:
        lock_err = !fuse_reg[region] || (page_w < boot_lim);
      ffs_pkg::C_EA:
        lock_err = !(&fuse_reg[15:0]) || (bp != ffs_pkg::BP_NONE);
      ffs_pkg::WRITE_FUSE_BIT_CMD, ffs_pkg::ERASE_FUSE_BIT_CMD:
        lock_err = sec_reg && (fidx >= 5'h10) && (fidx <= 5'h13);
      ffs_pkg::PROGRAM_FUSE_BYTE_CMD:
        lock_err = sec_reg && (fbyte == 3'h2);
      ffs_pkg::ERASE_ALL_FUSES_CMD:
        lock_err = sec_reg;
      default:
        lock_err = 1'b0;
    endcase
  end

  assign prog_set = cmd_wr && (busy || !key_ok || !code_ok);
  assign lock_set = go && lock_err;

  // Chip erase pin crosses in from outside
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ce_meta <= 1'b0;
      ce_sync <= 1'b0;
    end
    else
    begin
      ce_meta <= chip_erase_pin;
      ce_sync <= ce_meta;
    end
  end

  // Command sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (go)
          begin
            state_reg <= ST_BUSY;
            cnt_reg   <= EXEC_M1;
          end
        ST_BUSY:
          if (cnt_reg == 16'h0000)
            state_reg <= ST_IDLE;
          else
            cnt_reg <= cnt_reg - 16'h0001;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Fuse array; the external erase overrides every internal command
  always_ff @(posedge clk)
  begin
    if (rst)
      fuse_reg <= FUSE_INIT;
    else if (ce_sync)
      fuse_reg <= 32'hFFFFFFFF;
    else if (go && !lock_err)
    begin
      case (code_w)
        ffs_pkg::C_LP:   fuse_reg[region] <= 1'b0;
        ffs_pkg::C_UP:   fuse_reg[region] <= 1'b1;
        ffs_pkg::WRITE_FUSE_BIT_CMD: fuse_reg[fidx] <= 1'b0;
        ffs_pkg::ERASE_FUSE_BIT_CMD: fuse_reg[fidx] <= 1'b1;
        ffs_pkg::PROGRAM_FUSE_BYTE_CMD:
          if (fbyte < 3'h4)
            fuse_reg[fbyte[1:0]*8 +: 8] <= fval;
        ffs_pkg::ERASE_ALL_FUSES_CMD: fuse_reg <= 32'hFFFFFFFF;
        default:         fuse_reg <= fuse_reg;
      endcase
    end
  end

  // Security bit: sticky until external erase
  always_ff @(posedge clk)
  begin
    if (rst)
      sec_reg <= 1'b0;
    else if (ce_sync)
      sec_reg <= 1'b0;
    else if (go && code_w == ffs_pkg::SET_SECURITY_CMD)
      sec_reg <= 1'b1;
  end

  // Sticky error flags; a new event in the read cycle survives the clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prog_reg <= 1'b0;
      lock_reg <= 1'b0;
    end
    else
    begin
      prog_reg <= (prog_reg && !st_rd) || prog_set;
      lock_reg <= (lock_reg && !st_rd) || lock_set;
    end
  end

  // Page field, last command code and quick read result
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      page_reg <= 16'h0000;
      code_reg <= ffs_pkg::C_NOP;
      qpr_reg  <= 1'b0;
    end
    else
    begin
      if (go)
      begin
        page_reg <= page_w;
        code_reg <= code_w;
      end
      else if (pbuf_wr)
        page_reg <= pbuf_page & PG_MASK;
      if (busy && cnt_reg == 16'h0000 && code_reg == ffs_pkg::C_QPR)
        qpr_reg <= qpr_erased;
    end
  end

  // Operation handed to the array core for C_WP, C_EP, C_CPB, C_QPR and erase all
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      op_valid <= 1'b0;
      op       <= '0;
    end
    else
    begin
      op_valid <= go && !lock_err && (code_w == ffs_pkg::C_WP ||
                  code_w == ffs_pkg::C_EP || code_w == ffs_pkg::C_CPB ||
                  code_w == ffs_pkg::C_EA || code_w == ffs_pkg::C_QPR);
      if (go)
      begin
        op.code <= code_w;
        op.page <= page_w;
      end
    end
  end

  // Control register
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl <= '0;
    else if (reg_wr && reg_addr == ffs_pkg::OFF_CTRL)
    begin
      ctrl.br_en   <= reg_wdata[ffs_pkg::CB_BR];
      ctrl.seq_en  <= reg_wdata[ffs_pkg::CB_SEQ];
      ctrl.ws      <= reg_wdata[ffs_pkg::CB_WS];
      ctrl.ie_prog <= reg_wdata[ffs_pkg::CB_IE_PROG];
      ctrl.ie_lock <= reg_wdata[ffs_pkg::CB_IE_LOCK];
      ctrl.ie_rdy  <= reg_wdata[ffs_pkg::CB_IE_RDY];
    end
  end

  // Fuse-driven outputs and the interrupt line
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_priv_fetch_lock <= 1'b1;
      boot_area_size      <= ffs_pkg::BP_NONE;
      irq                 <= 1'b0;
    end
    else
    begin
      ext_priv_fetch_lock <= fuse_reg[ffs_pkg::F_EXT_PRIV_FETCH_LOCK];
      boot_area_size      <= bp;
      irq <= (ctrl.ie_prog && prog_reg) || (ctrl.ie_lock && lock_reg) ||
             (ctrl.ie_rdy && !busy);
    end
  end

  // Read port
  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      reg_rdata <= 32'h00000000;
      if (reg_addr == ffs_pkg::OFF_CTRL)
      begin
        reg_rdata[ffs_pkg::CB_BR]      <= ctrl.br_en;
        reg_rdata[ffs_pkg::CB_SEQ]     <= ctrl.seq_en;
        reg_rdata[ffs_pkg::CB_WS]      <= ctrl.ws;
        reg_rdata[ffs_pkg::CB_IE_PROG] <= ctrl.ie_prog;
        reg_rdata[ffs_pkg::CB_IE_LOCK] <= ctrl.ie_lock;
        reg_rdata[ffs_pkg::CB_IE_RDY]  <= ctrl.ie_rdy;
      end
      else if (reg_addr == ffs_pkg::OFF_CMD)
      begin
        reg_rdata[ffs_pkg::PAGE_LSB +: ffs_pkg::PAGE_W] <= page_reg;
        reg_rdata[ffs_pkg::CMD_LSB +: ffs_pkg::CMD_W]   <= code_reg;
      end
      else if (reg_addr == ffs_pkg::OFF_STATUS)
      begin
        reg_rdata[ffs_pkg::SB_RDY]  <= !busy;
        reg_rdata[ffs_pkg::SB_LOCK] <= lock_reg;
        reg_rdata[ffs_pkg::SB_PROG] <= prog_reg;
        reg_rdata[ffs_pkg::SB_SEC]  <= sec_reg;
        reg_rdata[ffs_pkg::SB_QPR]  <= qpr_reg;
        reg_rdata[ffs_pkg::SB_REG +: 16] <= ~fuse_reg[15:0];
      end
      else if (reg_addr == ffs_pkg::OFF_PARAM)
        reg_rdata <= PARAM_VAL;
      else if (reg_addr == ffs_pkg::OFF_VER)
        reg_rdata <= VERSION;
      else if (reg_addr == ffs_pkg::OFF_FUSE_L)
        reg_rdata <= fuse_reg;
    end
  end

  // Checks
  // Last busy cycle excluded: the sequencer may already return to idle there
  AST_BUSY_WRITE: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && busy && cnt_reg != 16'h0000 && !st_rd && !ce_sync) |=>
    prog_reg && busy && $stable(fuse_reg))
    else $error("command accepted while busy");

  AST_BAD_KEY: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && !key_ok && !busy && !ce_sync) |=>
    !busy && $stable(fuse_reg) && !op_valid)
    else $error("command acted on with wrong key");

  AST_READY_CYCLE: assert property (@(posedge clk) disable iff (rst)
    go |=> busy ##[1:1000] !busy)
    else $error("ready did not clear and return");

  AST_SEC_STICKY: assert property (@(posedge clk) disable iff (rst)
    (sec_reg && !ce_sync) |=> sec_reg)
    else $error("security bit dropped without chip erase");

  AST_SEC_FUSES: assert property (@(posedge clk) disable iff (rst)
    (sec_reg && !ce_sync) |=> $stable(fuse_reg[19:16]))
    else $error("protected fuses changed under security");

  AST_FUSE_ERASE_SEC: assert property (@(posedge clk) disable iff (rst)
    (go && sec_reg && code_w == ffs_pkg::ERASE_ALL_FUSES_CMD && !ce_sync) |=>
    lock_reg && $stable(fuse_reg))
    else $error("erase all fuses not refused");

  AST_BYTE2_SEC: assert property (@(posedge clk) disable iff (rst)
    (go && sec_reg && code_w == ffs_pkg::PROGRAM_FUSE_BYTE_CMD && fbyte == 3'h2) |=> lock_reg)
    else $error("fuse byte 2 program not refused");

  AST_BOOT_PAGE: assert property (@(posedge clk) disable iff (rst)
    (go && code_w == ffs_pkg::C_WP && page_w < boot_lim) |=> !op_valid && lock_reg)
    else $error("boot page write not blocked");

  AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (st_rd && !prog_set) |=> !prog_reg)
    else $error("programming error not cleared by status read");

  AST_FETCH_LOCK: assert property (@(posedge clk) disable iff (rst)
    ##1 ext_priv_fetch_lock == $past(fuse_reg[ffs_pkg::F_EXT_PRIV_FETCH_LOCK]))
    else $error("fetch lock output does not follow fuse");

  AST_BAD_CODE: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && key_ok && !code_ok) ##1 ctrl.ie_prog |-> ##1 irq)
    else $error("invalid code raised no interrupt");
endmodule
`default_nettype wire

// [tb/test_flash_fuse_security_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module test_flash_fuse_security_ctrl;
  localparam int EXEC = 4;
  logic               clk;
  logic               rst;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata;
  logic [31:0]        reg_rdata;
  logic               pbuf_wr;
  logic [15:0]        pbuf_page;
  logic               qpr_erased;
  logic               chip_erase_pin;
  ffs_pkg::ffs_op_t   op;
  logic               op_valid;
  ffs_pkg::ffs_ctrl_t ctrl;
  logic               ext_priv_fetch_lock;
  logic [2:0]         boot_area_size;
  logic               irq;
  logic [15:0]        lfsr;
  logic [31:0]        d;
  logic [31:0]        bad_words [3];
  logic [31:0]        sec_words [5];
  logic [5:0]         last_code;
  int                 n_mismatch;
  int                 n_tests;
  int                 n_op;
  int                 n0;

  ffs_ctrl #(
    .EXEC(EXEC)
  ) ffs_ctrl_i (
    .clk                (clk),
    .rst                (rst),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_rdata          (reg_rdata),
    .pbuf_wr            (pbuf_wr),
    .pbuf_page          (pbuf_page),
    .qpr_erased         (qpr_erased),
    .chip_erase_pin     (chip_erase_pin),
    .op                 (op),
    .op_valid           (op_valid),
    .ctrl               (ctrl),
    .ext_priv_fetch_lock(ext_priv_fetch_lock),
    .boot_area_size     (boot_area_size),
    .irq                (irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Operations handed to the core, counted to spot refused commands
  always @(posedge clk)
  begin
    if (op_valid === 1'b1)
    begin
      n_op <= n_op + 1;
      last_code <= op.code;
    end
  end

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] cmd_word(input logic [7:0] key, input logic [5:0] code,
                                           input logic [15:0] page);
    return {key, page, 2'b00, code};
  endfunction

  task automatic results;
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Last=0 keeps the strobe up so a second transfer follows back to back
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v,
                     input logic last);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    if (last)
    begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h0, 1'b1);
    chk(reg_rdata, exp);
  endtask

  task automatic cmd(input logic [5:0] code, input logic [15:0] page);
    bus(1'b1, 1'b0, ffs_pkg::OFF_CMD, cmd_word(ffs_pkg::CMD_KEY, code, page), 1'b1);
    tick(EXEC + 2);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    pbuf_wr = 1'b0;
    pbuf_page = 16'h0;
    qpr_erased = 1'b0;
    chip_erase_pin = 1'b0;
    lfsr = 16'd17159;
    n_mismatch = 0;
    n_tests = 0;
    n_op = 0;
    bad_words = '{cmd_word(8'h5A, ffs_pkg::WRITE_FUSE_BIT_CMD, 16'd20),
                  cmd_word(ffs_pkg::CMD_KEY, 6'h3F, 16'h0),
                  cmd_word(ffs_pkg::CMD_KEY, 6'h0D, 16'h0)};
    sec_words = '{cmd_word(ffs_pkg::CMD_KEY, ffs_pkg::ERASE_FUSE_BIT_CMD, 16'd17),
                  cmd_word(ffs_pkg::CMD_KEY, ffs_pkg::WRITE_FUSE_BIT_CMD, 16'd16),
                  cmd_word(ffs_pkg::CMD_KEY, ffs_pkg::PROGRAM_FUSE_BYTE_CMD, {5'h0, 8'h00, 3'd2}),
                  cmd_word(ffs_pkg::CMD_KEY, ffs_pkg::ERASE_ALL_FUSES_CMD, 16'h0),
                  cmd_word(ffs_pkg::CMD_KEY, ffs_pkg::C_EP, 16'h0002)};
    tick(10);
    rst = 1'b0;
    tick(1);
    rd_chk(ffs_pkg::OFF_CTRL, 32'h0);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h1);
    rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFFFFFFF);
    rd_chk(ffs_pkg::OFF_FUSE_H, 32'h0);
    rd_chk(8'h1C, 32'h0);
    chk(32'(ext_priv_fetch_lock), 32'h1);
    chk(32'(boot_area_size), 32'h7);
    repeat (4)
    begin
      lfsr = next_rand(lfsr);
      d = {lfsr, ~lfsr};
      bus(1'b1, 1'b0, ffs_pkg::OFF_CTRL, d, 1'b1);
      rd_chk(ffs_pkg::OFF_CTRL, d & 32'h0003004D);
      chk(32'(ctrl), 32'({d[17], d[16], d[6], d[3], d[2], d[0]}));
      tick(2);
      chk(32'(irq), 32'(d[0]));
    end
    bus(1'b1, 1'b0, ffs_pkg::OFF_CTRL, 32'h8, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, 1'b0, ffs_pkg::OFF_CMD, bad_words[i], 1'b1);
      tick(2);
      chk(32'(irq), 32'h1);
      rd_chk(ffs_pkg::OFF_STATUS, 32'h9);
      tick(2);
      chk(32'(irq), 32'h0);
      rd_chk(ffs_pkg::OFF_STATUS, 32'h1);
      rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFFFFFFF);
    end
    bus(1'b1, 1'b0, ffs_pkg::OFF_CMD,
        cmd_word(ffs_pkg::CMD_KEY, ffs_pkg::WRITE_FUSE_BIT_CMD, 16'd20), 1'b0);
    bus(1'b1, 1'b0, ffs_pkg::OFF_CMD,
        cmd_word(ffs_pkg::CMD_KEY, ffs_pkg::ERASE_FUSE_BIT_CMD, 16'd20), 1'b1);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h8);
    tick(EXEC + 2);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h1);
    rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFEFFFFF);
    cmd(ffs_pkg::ERASE_FUSE_BIT_CMD, 16'd20);
    rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFFFFFFF);
    cmd(ffs_pkg::C_NOP, 16'hFFFF);
    rd_chk(ffs_pkg::OFF_CMD, 32'h0001FF00);
    pbuf_wr = 1'b1;
    pbuf_page = 16'h1234;
    tick(1);
    pbuf_wr = 1'b0;
    rd_chk(ffs_pkg::OFF_CMD, 32'h00003400);
    bus(1'b1, 1'b0, ffs_pkg::OFF_CTRL, 32'h4, 1'b1);
    cmd(ffs_pkg::C_LP, 16'h0040);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h00040001);
    rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFFFFFFB);
    n0 = n_op;
    cmd(ffs_pkg::C_WP, 16'h0045);
    chk(32'(irq), 32'h1);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h00040005);
    chk(32'(n_op), 32'(n0));
    cmd(ffs_pkg::C_UP, 16'h0050);
    rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFFFFFFF);
    cmd(ffs_pkg::WRITE_FUSE_BIT_CMD, 16'd3);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h00080001);
    cmd(ffs_pkg::ERASE_FUSE_BIT_CMD, 16'd3);
    repeat (4)
    begin
      lfsr = next_rand(lfsr);
      cmd(ffs_pkg::PROGRAM_FUSE_BYTE_CMD, {5'h0, lfsr[7:0], 3'd3});
      rd_chk(ffs_pkg::OFF_FUSE_L, {lfsr[7:0], 24'hFFFFFF});
      cmd(ffs_pkg::ERASE_ALL_FUSES_CMD, 16'h0);
    end
    cmd(ffs_pkg::PROGRAM_FUSE_BYTE_CMD, {5'h0, 8'h5A, 3'd1});
    rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFFF5AFF);
    rd_chk(ffs_pkg::OFF_STATUS, 32'hA5000001);
    cmd(ffs_pkg::ERASE_ALL_FUSES_CMD, 16'h0);
    rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFFFFFFF);
    cmd(ffs_pkg::PROGRAM_FUSE_BYTE_CMD, {5'h0, 8'hFA, 3'd2});
    chk(32'(ext_priv_fetch_lock), 32'h0);
    chk(32'(boot_area_size), 32'h5);
    n0 = n_op;
    cmd(ffs_pkg::C_WP, 16'h0001);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h5);
    cmd(ffs_pkg::C_EP, 16'h0004);
    chk(32'(n_op), 32'(n0 + 1));
    cmd(ffs_pkg::ERASE_FUSE_BIT_CMD, 16'd16);
    chk(32'(ext_priv_fetch_lock), 32'h1);
    cmd(ffs_pkg::SET_SECURITY_CMD, 16'h0);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h11);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, 1'b0, ffs_pkg::OFF_CMD, sec_words[i], 1'b1);
      tick(EXEC + 2);
      rd_chk(ffs_pkg::OFF_STATUS, 32'h15);
    end
    chk(32'(ext_priv_fetch_lock), 32'h1);
    chk(32'(boot_area_size), 32'h5);
    rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFFBFFFF);
    // Pin is synchronised, so hold it well past the two-stage delay
    chip_erase_pin = 1'b1;
    tick(4);
    chip_erase_pin = 1'b0;
    tick(4);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h1);
    rd_chk(ffs_pkg::OFF_FUSE_L, 32'hFFFFFFFF);
    chk(32'(boot_area_size), 32'h7);
    qpr_erased = 1'b1;
    n0 = n_op;
    cmd(ffs_pkg::C_QPR, 16'h0100);
    rd_chk(ffs_pkg::OFF_STATUS, 32'h21);
    chk(32'(n_op), 32'(n0 + 1));
    chk(32'(last_code), 32'(ffs_pkg::C_QPR));
    chk(32'(op.page), 32'h0100);
    results();
  end
endmodule
`default_nettype wire
